// ==== include/fifo_thresh_regs.svh ====
// Register offsets, field positions, reset values and sizes of the bank
`ifndef FIFO_THRESH_REGS_SVH
`define FIFO_THRESH_REGS_SVH
`define ADDR_WATERMARK_CFG 8'hC3
`define ADDR_OCCUPANCY 8'hC4
`define ADDR_WIRING 8'hC5
`define ADDR_ABS_LOW 8'hC7
`define ADDR_ABS_HIGH 8'hC8
`define ADDR_DELTA_LOW 8'hC9
`define ADDR_DELTA_HIGH 8'hCA
`define RST_WATERMARK_CFG 8'h00
`define RST_OCCUPANCY 8'h40
`define RST_WIRING 8'h00
`define RST_THRESHOLD 16'h0000
`define FLUSH_BIT 7
`define EMPTY_BIT 6
`define FULL_BIT 5
`define WIRING_BIT 0
`define FIFO_FULL_LEVEL 5'h10
`define FLAG_OVERFLOW 0
`define FLAG_UNDERFLOW 1
`define FLAG_WM_HIGH 2
`define FLAG_WM_LOW 3
`define FLAG_ABS 5
`define FLAG_DELTA 6
`define FLAG_USED_MASK 8'h6F
`endif

// ==== include/fifo_thresh_pkg.sv ====
// Types carried between the register bank and its neighbours
package fifo_thresh_pkg;
    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } host_req_type;
    typedef struct packed {
        logic pair_push;
        logic pair_pop;
        logic press_valid;
        logic signed [15:0] press_code;
    } meas_event_type;
endpackage

// ==== design/fifo_and_threshold_registers.sv ====
// FIFO watermark, occupancy, wiring select and pressure threshold bank
//
// Notes on behaviour
// - Rising level equal to nonzero upper watermark raises high-mark flag.
// - Upper watermark of zero disables the high-mark check entirely.
// - Falling level equal to lower watermark raises low-mark flag.
// - Writing one to flush bit empties FIFO; writing zero changes nothing.
// - Empty bit reads one exactly when level is zero.
// - Full bit reads one when level reaches sixteen.
// - Level counts sixteenths, zero to 10000; higher codes never appear.
// - Wiring bit: zero four-wire, one three-wire with shared data line.
// - Absolute threshold is sixteen bits from low and high byte.
// - Delta threshold is sixteen bits from low and high byte.
// - Absolute flag sets when a result crosses threshold either way.
// - Delta flag sets when consecutive results differ beyond threshold.
// - Overflow flag sets when a pair arrives with no fetch while FIFO is full.
// - Status flags stay set until host writes one; zero leaves them.
`timescale 1ns/10ps
`include "fifo_thresh_regs.svh"

module fifo_and_threshold_registers
    import fifo_thresh_pkg::*;
(
    input wire logic ref_clk,
    input wire logic srst,
    input wire host_req_type host_req,
    input wire meas_event_type meas,
    input wire logic [7:0] flag_clear,
    output logic [7:0] read_data,
    output logic [7:0] status_flags,
    output logic [4:0] fifo_level,
    output logic fifo_flush,
    output logic three_wire,
    output logic signed [15:0] abs_threshold,
    output logic [15:0] delta_threshold
);

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    logic [7:0] watermark_cfg;
    logic signed [15:0] prev_code;
    logic prev_valid;
    logic [7:0] next_read_data;
    logic [7:0] next_status_flags;
    logic [4:0] next_fifo_level;
    logic next_fifo_flush;
    logic next_three_wire;
    logic signed [15:0] next_abs_threshold;
    logic [15:0] next_delta_threshold;
    logic [7:0] next_watermark_cfg;
    logic signed [15:0] next_prev_code;
    logic next_prev_valid;

    logic [3:0] upper_watermark;
    logic [3:0] lower_watermark;
    logic flush_req;
    logic [7:0] events;
    logic signed [16:0] diff;
    logic [16:0] magnitude;
    logic above_now;
    logic above_prev;

    assign upper_watermark = watermark_cfg[7:4];
    assign lower_watermark = watermark_cfg[3:0];
    assign flush_req = host_req.wr && host_req.addr == `ADDR_OCCUPANCY
        && host_req.wdata[`FLUSH_BIT];

    // ------------------------------------------------------------
    // Next-value logic
    // ------------------------------------------------------------
    always_comb begin
        next_watermark_cfg = watermark_cfg;
        next_three_wire = three_wire;
        next_abs_threshold = abs_threshold;
        next_delta_threshold = delta_threshold;
        next_fifo_level = fifo_level;
        next_fifo_flush = flush_req;
        next_prev_code = prev_code;
        next_prev_valid = prev_valid;
        events = 8'h00;
        diff = 17'sh0;
        magnitude = 17'h0;
        above_now = 1'b0;
        above_prev = 1'b0;

        if (host_req.wr) begin
            unique case (host_req.addr)
                `ADDR_WATERMARK_CFG: next_watermark_cfg = host_req.wdata;
                `ADDR_WIRING:
                    next_three_wire = host_req.wdata[`WIRING_BIT];
                `ADDR_ABS_LOW:
                    next_abs_threshold[7:0] = host_req.wdata;
                `ADDR_ABS_HIGH:
                    next_abs_threshold[15:8] = host_req.wdata;
                `ADDR_DELTA_LOW:
                    next_delta_threshold[7:0] = host_req.wdata;
                `ADDR_DELTA_HIGH:
                    next_delta_threshold[15:8] = host_req.wdata;
                default: ;
            endcase
        end

        // Flush beats any push or fetch in the same cycle
        if (flush_req) begin
            next_fifo_level = 5'h00;
        end else if (meas.pair_push && !meas.pair_pop) begin
            if (fifo_level == `FIFO_FULL_LEVEL) begin
                events[`FLAG_OVERFLOW] = 1'b1;
            end else begin
                next_fifo_level = fifo_level + 5'h01;
            end
        end else if (meas.pair_pop && !meas.pair_push) begin
            if (fifo_level == 5'h00) begin
                events[`FLAG_UNDERFLOW] = 1'b1;
            end else begin
                next_fifo_level = fifo_level - 5'h01;
            end
        end else if (meas.pair_pop && fifo_level == 5'h00) begin
            // Fetch from an empty FIFO still underflows
            events[`FLAG_UNDERFLOW] = 1'b1;
            next_fifo_level = 5'h01;
        end

        if (next_fifo_level > fifo_level && upper_watermark != 4'h0
            && next_fifo_level == {1'b0, upper_watermark}) begin
            events[`FLAG_WM_HIGH] = 1'b1;
        end
        if (next_fifo_level < fifo_level
            && next_fifo_level == {1'b0, lower_watermark}) begin
            events[`FLAG_WM_LOW] = 1'b1;
        end

        if (meas.press_valid) begin
            above_now = meas.press_code >= abs_threshold;
            above_prev = prev_code >= abs_threshold;
            diff = 17'(meas.press_code) - 17'(prev_code);
            magnitude = diff[16] ? 17'(-diff) : 17'(diff);
            if (prev_valid && above_now != above_prev) begin
                events[`FLAG_ABS] = 1'b1;
            end
            if (prev_valid && magnitude > {1'b0, delta_threshold}) begin
                events[`FLAG_DELTA] = 1'b1;
            end
            next_prev_code = meas.press_code;
            next_prev_valid = 1'b1;
        end

        // A new event wins over a clear arriving in the same cycle
        next_status_flags = ((status_flags & ~flag_clear) | events)
            & `FLAG_USED_MASK;

        next_read_data = 8'h00;
        if (host_req.rd) begin
            unique case (host_req.addr)
                `ADDR_WATERMARK_CFG: next_read_data = watermark_cfg;
                `ADDR_OCCUPANCY: next_read_data = {1'b0,
                    fifo_level == 5'h00, fifo_level == `FIFO_FULL_LEVEL,
                    fifo_level};
                `ADDR_WIRING: next_read_data = {7'h00, three_wire};
                `ADDR_ABS_LOW: next_read_data = abs_threshold[7:0];
                `ADDR_ABS_HIGH: next_read_data = abs_threshold[15:8];
                `ADDR_DELTA_LOW: next_read_data = delta_threshold[7:0];
                `ADDR_DELTA_HIGH: next_read_data = delta_threshold[15:8];
                default: next_read_data = 8'h00;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            watermark_cfg <= `RST_WATERMARK_CFG;
            three_wire <= 1'(`RST_WIRING);
            abs_threshold <= `RST_THRESHOLD;
            delta_threshold <= `RST_THRESHOLD;
            fifo_level <= 5'h00;
            fifo_flush <= 1'b0;
            status_flags <= 8'h00;
            read_data <= 8'h00;
            prev_code <= 16'sh0000;
            prev_valid <= 1'b0;
        end else begin
            watermark_cfg <= next_watermark_cfg;
            three_wire <= next_three_wire;
            abs_threshold <= next_abs_threshold;
            delta_threshold <= next_delta_threshold;
            fifo_level <= next_fifo_level;
            fifo_flush <= next_fifo_flush;
            status_flags <= next_status_flags;
            read_data <= next_read_data;
            prev_code <= next_prev_code;
            prev_valid <= next_prev_valid;
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (srst);

    level_in_range_a: assert property (fifo_level <= 5'h10)
        else $error("fifo level above full");
    flush_empties_a: assert property (flush_req |=> fifo_level == 5'h00
        && fifo_flush) else $error("flush did not empty fifo");
    flush_zero_a: assert property (host_req.wr
        && host_req.addr == `ADDR_OCCUPANCY && !host_req.wdata[7]
        && !meas.pair_push && !meas.pair_pop |=> $stable(fifo_level))
        else $error("zero flush bit changed level");
    fill_read_a: assert property (host_req.rd
        && host_req.addr == `ADDR_OCCUPANCY |=> read_data[6]
        == ($past(fifo_level) == 5'h00) && read_data[5]
        == ($past(fifo_level) == 5'h10)) else $error("bad empty/full bits");
    wm_high_hit_a: assert property (meas.pair_push && !meas.pair_pop
        && !flush_req && upper_watermark != 4'h0
        && fifo_level + 5'h01 == {1'b0, upper_watermark}
        |=> status_flags[2]) else $error("high watermark missed");
    wm_zero_off_a: assert property ($rose(status_flags[2])
        |-> $past(upper_watermark) != 4'h0)
        else $error("high flag with zero watermark");
    wm_low_hit_a: assert property (meas.pair_pop && !meas.pair_push
        && !flush_req && fifo_level != 5'h00
        && fifo_level - 5'h01 == {1'b0, lower_watermark}
        |=> status_flags[3]) else $error("low watermark missed");
    overflow_set_a: assert property (meas.pair_push && !meas.pair_pop
        && !flush_req && fifo_level == 5'h10 |=> status_flags[0]
        && fifo_level == 5'h10) else $error("overflow not flagged");
    flag_hold_a: assert property (status_flags[5] && !flag_clear[5]
        |=> status_flags[5]) else $error("abs flag dropped uncleared");
    wiring_write_a: assert property (host_req.wr
        && host_req.addr == `ADDR_WIRING |=> three_wire
        == $past(host_req.wdata[0])) else $error("wiring bit not written");

    fill_to_full_c: cover property (fifo_level == 5'h0F ##1
        fifo_level == 5'h10);
    abs_cross_c: cover property ($rose(status_flags[5]));
    delta_hit_c: cover property ($rose(status_flags[6]));
    flush_full_c: cover property (fifo_level == 5'h10 && flush_req);

endmodule

// ==== tb/host_partner.sv ====
// Host and measurement-source model facing the register bank
`timescale 1ns/10ps
module host_partner
    import fifo_thresh_pkg::*;
(
    input wire logic ref_clk,
    input wire logic [7:0] read_data,
    output host_req_type host_req,
    output meas_event_type meas,
    output logic [7:0] flag_clear
);
    initial begin
        host_req = '0;
        meas = '0;
        flag_clear = 8'h00;
    end
    // Released address and data lines show an inverted pattern, never the last value
    task automatic release_bus();
        host_req.wr = 1'b0;
        host_req.rd = 1'b0;
        host_req.addr = ~host_req.addr;
        host_req.wdata = ~host_req.wdata;
    endtask
    // Callers write thresholds and flush only with no events running
    task automatic wr_reg(input logic [7:0] a,
                          input logic [7:0] d);
        @(negedge ref_clk);
        host_req.wr = 1'b1;
        host_req.addr = a;
        host_req.wdata = d;
        @(negedge ref_clk);
        release_bus();
    endtask
    task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
        @(negedge ref_clk);
        host_req.rd = 1'b1;
        host_req.addr = a;
        @(negedge ref_clk);
        d = read_data;
        release_bus();
    endtask
    task automatic pairs(input logic push, input logic pop, input int n);
        repeat (n) begin
            @(negedge ref_clk);
            meas.pair_push = push;
            meas.pair_pop = pop;
            @(negedge ref_clk);
            meas.pair_push = 1'b0;
            meas.pair_pop = 1'b0;
        end
    endtask
    task automatic result(input logic signed [15:0] c);
        @(negedge ref_clk);
        meas.press_valid = 1'b1;
        meas.press_code = c;
        @(negedge ref_clk);
        meas.press_valid = 1'b0;
        meas.press_code = ~c;
    endtask
    task automatic clear(input logic [7:0] m);
        @(negedge ref_clk);
        flag_clear = m;
        @(negedge ref_clk);
        flag_clear = 8'h00;
    endtask
endmodule

// ==== tb/fifo_and_threshold_registers_tb_top.sv ====
// Self-checking bench for the FIFO and threshold register bank
`timescale 1ns/10ps
`include "fifo_thresh_regs.svh"
module fifo_and_threshold_registers_tb_top
    import fifo_thresh_pkg::*;
;
    logic ref_clk = 1'b0;
    logic srst = 1'b1;
    host_req_type host_req;
    meas_event_type meas;
    logic [7:0] flag_clear, read_data, status_flags, rd;
    logic [4:0] fifo_level;
    logic fifo_flush, three_wire;
    logic signed [15:0] abs_threshold;
    logic [15:0] delta_threshold;
    int miscompares = 0;
    int checked = 0;
    fifo_and_threshold_registers dut (.ref_clk(ref_clk), .srst(srst),
        .host_req(host_req), .meas(meas), .flag_clear(flag_clear),
        .read_data(read_data), .status_flags(status_flags),
        .fifo_level(fifo_level), .fifo_flush(fifo_flush),
        .three_wire(three_wire), .abs_threshold(abs_threshold),
        .delta_threshold(delta_threshold));
    host_partner host (.ref_clk(ref_clk), .read_data(read_data),
        .host_req(host_req), .meas(meas), .flag_clear(flag_clear));
    initial begin
        forever #25 ref_clk = ~ref_clk;
    end
    // ----------------------------------------
    // Checks and tests
    // ----------------------------------------
    task automatic chk(input string what, input logic [15:0] e,
                       input logic [15:0] g);
        checked++;
        if (g !== e) begin
            miscompares++;
            $display("ERROR %s expected %h seen %h", what, e, g);
        end
    endtask
    task automatic rchk(input logic [7:0] a, input logic [7:0] e);
        host.rd_reg(a, rd);
        chk($sformatf("reg %h", a), {8'h00, e}, {8'h00, rd});
    endtask
    task automatic t_reset();
        rchk(`ADDR_WATERMARK_CFG, 8'h00);
        rchk(`ADDR_OCCUPANCY, 8'h40);
        rchk(`ADDR_WIRING, 8'h00);
        rchk(8'hC6, 8'h00);
        for (int a = 8'hC7; a <= 8'hCA; a++) begin
            rchk(8'(a), 8'h00);
        end
        $display("test reset done");
    endtask
    task automatic t_wiring();
        host.wr_reg(`ADDR_WIRING, 8'hFF);
        chk("three_wire", 16'h0001, {15'h0, three_wire});
        rchk(`ADDR_WIRING, 8'h01);
        host.wr_reg(`ADDR_WIRING, 8'h00);
        chk("three_wire", 16'h0000, {15'h0, three_wire});
        $display("test wiring done");
    endtask
    task automatic t_flush();
        host.pairs(1'b1, 1'b0, 3);
        chk("no high mark", 16'h0, {15'h0, status_flags[2]});
        host.wr_reg(`ADDR_OCCUPANCY, 8'h00);
        chk("level kept", 16'h3, {11'h0, fifo_level});
        host.wr_reg(`ADDR_OCCUPANCY, 8'h80);
        chk("flush pulse", 16'h1, {15'h0, fifo_flush});
        repeat (2) @(negedge ref_clk);
        chk("level flushed", 16'h0, {11'h0, fifo_level});
        host.clear(8'hFF);
        $display("test flush done");
    endtask
    task automatic t_fill();
        host.wr_reg(`ADDR_WATERMARK_CFG, 8'h42);
        rchk(`ADDR_WATERMARK_CFG, 8'h42);
        host.pairs(1'b1, 1'b0, 4);
        chk("high mark", 16'h04, {8'h0, status_flags});
        host.pairs(1'b1, 1'b0, 12);
        rchk(`ADDR_OCCUPANCY, 8'h30);
        host.pairs(1'b1, 1'b0, 1);
        chk("sat level", 16'h10, {11'h0, fifo_level});
        chk("overflow", 16'h05, {8'h0, status_flags});
        host.clear(8'h01);
        chk("sticky", 16'h04, {8'h0, status_flags});
        host.clear(8'hFF);
        host.pairs(1'b0, 1'b1, 14);
        chk("low mark", 16'h08, {8'h0, status_flags});
        host.pairs(1'b0, 1'b1, 2);
        rchk(`ADDR_OCCUPANCY, 8'h40);
        host.pairs(1'b0, 1'b1, 1);
        chk("underflow", 16'h0A, {8'h0, status_flags});
        chk("empty level", 16'h0, {11'h0, fifo_level});
        host.clear(8'hFF);
        host.pairs(1'b1, 1'b1, 1);
        chk("push pop empty", 16'h01, {11'h0, fifo_level});
        chk("push pop flags", 16'h02, {8'h0, status_flags});
        host.pairs(1'b1, 1'b1, 1);
        chk("push pop held", 16'h01, {11'h0, fifo_level});
        host.wr_reg(`ADDR_OCCUPANCY, 8'h80);
        chk("flush one", 16'h0, {11'h0, fifo_level});
        host.clear(8'hFF);
        $display("test fill done");
    endtask
    task automatic t_thresh();
        host.wr_reg(`ADDR_ABS_LOW, 8'h00);
        host.wr_reg(`ADDR_ABS_HIGH, 8'h08);
        chk("abs", 16'h0800, abs_threshold);
        host.wr_reg(`ADDR_DELTA_LOW, 8'h66);
        host.wr_reg(`ADDR_DELTA_HIGH, 8'h00);
        chk("delta", 16'h0066, delta_threshold);
        rchk(`ADDR_ABS_HIGH, 8'h08);
        rchk(`ADDR_DELTA_LOW, 8'h66);
        host.result(16'h0000);
        chk("first result", 16'h00, {8'h0, status_flags});
        host.result(16'h0900);
        chk("up cross", 16'h60, {8'h0, status_flags});
        host.clear(8'h60);
        host.result(16'h0910);
        chk("small step", 16'h00, {8'h0, status_flags});
        host.result(16'hF000);
        chk("down cross", 16'h60, {8'h0, status_flags});
        host.clear(8'hFF);
        host.result(16'hF066);
        chk("delta edge", 16'h00, {8'h0, status_flags});
        $display("test thresholds done");
    endtask
    task automatic t_midreset();
        host.wr_reg(`ADDR_WIRING, 8'h01);
        host.pairs(1'b1, 1'b0, 1);
        @(negedge ref_clk);
        srst = 1'b1;
        repeat (2) @(negedge ref_clk);
        srst = 1'b0;
        chk("reset level", 16'h0, {11'h0, fifo_level});
        chk("reset wiring", 16'h0, {15'h0, three_wire});
        chk("reset abs", 16'h0, abs_threshold);
        chk("reset delta", 16'h0, delta_threshold);
        rchk(`ADDR_WATERMARK_CFG, 8'h00);
        host.result(16'h0900);
        chk("stored only", 16'h00, {8'h0, status_flags});
        $display("test mid-run reset done");
    endtask
    task automatic test_done();
        $display("checked %0d miscompares %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    initial begin
        repeat (4000) @(posedge ref_clk);
        miscompares++;
        test_done();
    end
    initial begin
        repeat (16) @(negedge ref_clk);
        srst = 1'b0;
        t_reset();
        t_wiring();
        t_flush();
        t_fill();
        t_thresh();
        t_midreset();
        test_done();
    end
endmodule
